// ===== eau_pkg.sv
// package: constants, types and decode functions of the address unit
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - sixty-one basic instructions in five classes
// - ten addressing modes form the operand address
// - inherent operations take everything from the opcode alone
// - immediate operand is the byte after opcode; pc advances two
// - direct address is zero high byte, next byte low; pc plus two
// - extended address is next two bytes, high first; pc plus three
// - indexed no offset uses index as low byte, zero high; one byte
// - indexed 8-bit offset adds unsigned byte to index; two bytes
// - taken branch adds signed offset to program counter
// - bit set or clear reaches any bit of the first 128 bytes
// - bit set or clear never alters the program-memory area
// - one instruction tests a bit in low 256 bytes and branches
// - tested bit is copied into carry whether or not branch taken
// - read-modify-write reads, modifies, writes back same place
// - negative-or-zero test reads and sets flags, writes nothing
// - register/memory ops use accumulator or index plus memory
// - jump and subroutine call load the address into pc
// - indexed 16-bit offset adds index to next two bytes; pc plus three
// - relative offset added to pc plus two only when condition holds
// - bit number from three opcode bits, byte from direct address
// - test bit from low nibble, address second byte, offset third
package eau_pkg;

  // instruction classes by opcode high nibble
  localparam logic [3:0] CLS_BTB     = 4'h0;
  localparam logic [3:0] CLS_BSC     = 4'h1;
  localparam logic [3:0] CLS_BRA     = 4'h2;
  localparam logic [3:0] CLS_RMW_A   = 4'h4;
  localparam logic [3:0] CLS_RMW_X   = 4'h5;
  localparam logic [3:0] CLS_RMW_IX1 = 4'h6;
  localparam logic [3:0] CLS_RMW_IX  = 4'h7;
  localparam logic [3:0] CLS_CTL8    = 4'h8;
  localparam logic [3:0] CLS_CTL9    = 4'h9;
  localparam logic [3:0] CLS_IMM     = 4'ha;
  localparam logic [3:0] CLS_EXT     = 4'hc;
  localparam logic [3:0] CLS_IX2     = 4'hd;
  localparam logic [3:0] CLS_IX1     = 4'he;
  localparam logic [3:0] CLS_IX      = 4'hf;

  // low nibble codes of register/memory class
  localparam logic [3:0] LO_CPX = 4'h3;
  localparam logic [3:0] LO_STA = 4'h7;
  localparam logic [3:0] LO_JMP = 4'hc;
  localparam logic [3:0] LO_JSR = 4'hd;
  localparam logic [3:0] LO_STX = 4'hf;

  // single opcodes
  localparam logic [7:0] OPC_RTS = 8'h81;
  localparam logic [7:0] OPC_CLC = 8'h98;
  localparam logic [7:0] OPC_SEC = 8'h99;
  localparam logic [7:0] OPC_CLI = 8'h9a;
  localparam logic [7:0] OPC_SEI = 8'h9b;
  localparam logic [7:0] OPC_RSP = 8'h9c;
  localparam logic [7:0] OPC_TAX = 8'h97;
  localparam logic [7:0] OPC_TXA = 8'h9f;
  localparam logic [7:0] OPC_BSR = 8'had;

  // condition code bit positions and reset value
  localparam int         CC_C      = 0;
  localparam int         CC_Z      = 1;
  localparam int         CC_N      = 2;
  localparam int         CC_I      = 3;
  localparam int         CC_H      = 4;
  localparam logic [4:0] CCR_RESET = 5'h08;

  // bit operations write only below this address
  localparam logic [15:0] BIT_ZONE_END = 16'h0080;

  typedef enum logic [4:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR,
    ALU_LD, ALU_TST, ALU_INC, ALU_DEC, ALU_CLR, ALU_COM, ALU_NEG,
    ALU_ROL, ALU_ROR, ALU_LSL, ALU_LSR, ALU_ASR
  } eau_alu_e;

  typedef enum logic [9:0] {
    ST_FETCH = 10'h001,
    ST_DEC   = 10'h002,
    ST_B1    = 10'h004,
    ST_B2    = 10'h008,
    ST_OPR   = 10'h010,
    ST_BRB   = 10'h020,
    ST_PSHL  = 10'h040,
    ST_PSHH  = 10'h080,
    ST_POPH  = 10'h100,
    ST_POPL  = 10'h200
  } eau_state_e;

  // register/memory low nibble to alu function
  function automatic eau_alu_e rm_fn(input logic [3:0] lo);
    unique case (lo)
      4'h2:    rm_fn = ALU_SBC;
      4'h4:    rm_fn = ALU_AND;
      4'h5:    rm_fn = ALU_AND;
      4'h6:    rm_fn = ALU_LD;
      4'h8:    rm_fn = ALU_EOR;
      4'h9:    rm_fn = ALU_ADC;
      4'ha:    rm_fn = ALU_OR;
      4'hb:    rm_fn = ALU_ADD;
      4'he:    rm_fn = ALU_LD;
      4'h0:    rm_fn = ALU_SUB;
      4'h1:    rm_fn = ALU_SUB;
      4'h3:    rm_fn = ALU_SUB;
      default: rm_fn = ALU_TST;
    endcase
  endfunction

  // register/memory destination: 0 none, 1 accumulator, 2 index
  function automatic logic [1:0] rm_dst(input logic [3:0] lo);
    unique case (lo)
      4'h1, 4'h3, 4'h5, 4'h7, 4'hc, 4'hd, 4'hf: rm_dst = 2'h0;
      4'he:    rm_dst = 2'h2;
      default: rm_dst = 2'h1;
    endcase
  endfunction

  // read-modify-write low nibble to alu function
  function automatic eau_alu_e rmw_fn(input logic [3:0] lo);
    unique case (lo)
      4'h0:    rmw_fn = ALU_NEG;
      4'h3:    rmw_fn = ALU_COM;
      4'h4:    rmw_fn = ALU_LSR;
      4'h6:    rmw_fn = ALU_ROR;
      4'h7:    rmw_fn = ALU_ASR;
      4'h8:    rmw_fn = ALU_LSL;
      4'h9:    rmw_fn = ALU_ROL;
      4'ha:    rmw_fn = ALU_DEC;
      4'hc:    rmw_fn = ALU_INC;
      4'hf:    rmw_fn = ALU_CLR;
      default: rmw_fn = ALU_TST;
    endcase
  endfunction

  // read-modify-write ops that write back (test and gaps do not)
  function automatic logic rmw_wr(input logic [3:0] lo);
    rmw_wr = (rmw_fn(lo) != ALU_TST);
  endfunction

endpackage

// ===== eau_alu_if.sv
// interface: operands and results between sequencer and alu
`timescale 1ns/1ps
interface eau_alu_if;
  import eau_pkg::*;
  eau_alu_e   fn;
  logic [7:0] a;
  logic [7:0] b;
  logic       cin;
  logic [7:0] res;
  logic       c;
  logic       h;
  logic       c_upd;
  logic       h_upd;
  modport core (output fn, a, b, cin, input res, c, h, c_upd, h_upd);
  modport alu  (input fn, a, b, cin, output res, c, h, c_upd, h_upd);
endinterface

// ===== eau_alu.sv
// module: eight-bit arithmetic and shift unit
`timescale 1ns/1ps
module eau_alu
  import eau_pkg::*;
(
  eau_alu_if.alu p
);

  ////////////////////////////////////////////////////////////////////////////
  // result, carry and half carry
  always_comb
  begin
    logic [8:0] s;
    s       = 9'h000;
    p.c_upd = 1'b1;
    p.h_upd = 1'b0;
    unique case (p.fn)
      ALU_ADD, ALU_ADC:
      begin
        s = {1'b0, p.a} + {1'b0, p.b} + {8'h00, p.fn == ALU_ADC && p.cin};
        p.h_upd = 1'b1;
      end
      ALU_SUB, ALU_SBC:
        s = {1'b0, p.a} - {1'b0, p.b} - {8'h00, p.fn == ALU_SBC && p.cin};
      ALU_NEG: s = {p.a != 8'h00, 8'h00 - p.a};
      ALU_COM: s = {1'b1, ~p.a};
      ALU_ROL: s = {p.a, p.cin};
      ALU_LSL: s = {p.a, 1'b0};
      ALU_ROR: s = {p.a[0], p.cin, p.a[7:1]};
      ALU_LSR: s = {p.a[0], 1'b0, p.a[7:1]};
      ALU_ASR: s = {p.a[0], p.a[7], p.a[7:1]};
      default:
      begin
        p.c_upd = 1'b0;
        unique case (p.fn)
          ALU_AND: s[7:0] = p.a & p.b;
          ALU_OR:  s[7:0] = p.a | p.b;
          ALU_EOR: s[7:0] = p.a ^ p.b;
          ALU_LD:  s[7:0] = p.b;
          ALU_INC: s[7:0] = p.a + 8'h01;
          ALU_DEC: s[7:0] = p.a - 8'h01;
          ALU_CLR: s[7:0] = 8'h00;
          default: s[7:0] = p.a;   // test passes operand through
        endcase
      end
    endcase
    p.res = s[7:0];
    p.c   = s[8];
    p.h   = (p.a[3] & p.b[3]) | (p.b[3] & ~s[3]) | (~s[3] & p.a[3]);
  end

endmodule

// ===== eau_effective_address_unit.sv
// module: instruction sequencer and effective address former
`timescale 1ns/1ps
module eau_effective_address_unit
  import eau_pkg::*;
#(
  parameter logic [15:0] RESET_PC  = 16'h0000,
  parameter logic [15:0] STACK_TOP = 16'h007f
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        irq_line,
  output logic      [15:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  output logic      [7:0]  acc,
  output logic      [7:0]  idx,
  output logic      [15:0] pc,
  output logic      [4:0]  ccr
);

  eau_state_e  state_reg;
  eau_state_e  state_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [7:0]  acc_reg;
  logic [7:0]  acc_next;
  logic [7:0]  idx_reg;
  logic [7:0]  idx_next;
  logic [4:0]  ccr_reg;
  logic [4:0]  ccr_next;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic [15:0] ea_reg;
  logic [15:0] ea_next;
  logic [7:0]  op_reg;
  logic [7:0]  op_next;
  logic [7:0]  b1_reg;
  logic [7:0]  b1_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic        rd_reg;
  logic        rd_next;
  logic        wr_reg;
  logic        wr_next;
  logic [7:0]  wdata_reg;
  logic [7:0]  wdata_next;

  logic [7:0]  op;
  logic [3:0]  hi;
  logic [3:0]  lo;
  logic        regmem;
  logic [15:0] rel;
  logic [15:0] operand_location;
  logic        go_ea;
  logic        fl;
  logic        cond;
  logic [7:0]  mask;

  eau_alu_if alu_bus ();

  eau_alu u_alu (
    .p (alu_bus.alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // opcode in view: fresh from memory while decoding
  assign op     = (state_reg == ST_DEC) ? mem_rdata : op_reg;
  assign hi     = op[7:4];
  assign lo     = op[3:0];
  assign regmem = (hi >= CLS_IMM);
  assign rel    = {{8{mem_rdata[7]}}, mem_rdata};
  assign mask   = 8'h01 << op[3:1];

  // alu operand steering
  always_comb
  begin
    alu_bus.cin = ccr_reg[CC_C];
    alu_bus.b   = mem_rdata;
    if (regmem)
    begin
      alu_bus.fn = rm_fn(lo);
      alu_bus.a  = (lo == LO_CPX || lo == LO_STX) ? idx_reg : acc_reg;
    end
    else
    begin
      alu_bus.fn = rmw_fn(lo);
      if (hi == CLS_RMW_A)
        alu_bus.a = acc_reg;
      else if (hi == CLS_RMW_X)
        alu_bus.a = idx_reg;
      else
        alu_bus.a = mem_rdata;
    end
  end

  // relative branch condition from condition codes or the interrupt line
  always_comb
  begin
    unique case (lo[3:1])
      3'h0: cond = 1'b1;
      3'h1: cond = ~(ccr_reg[CC_C] | ccr_reg[CC_Z]);
      3'h2: cond = ~ccr_reg[CC_C];
      3'h3: cond = ~ccr_reg[CC_Z];
      3'h4: cond = ~ccr_reg[CC_H];
      3'h5: cond = ~ccr_reg[CC_N];
      3'h6: cond = ~ccr_reg[CC_I];
      default: cond = ~irq_line;
    endcase
    cond = cond ^ lo[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and address forming
  always_comb
  begin
    state_next       = state_reg;
    pc_next          = pc_reg;
    acc_next         = acc_reg;
    idx_next         = idx_reg;
    ccr_next         = ccr_reg;
    sp_next          = sp_reg;
    ea_next          = ea_reg;
    op_next          = op_reg;
    b1_next          = b1_reg;
    addr_next        = addr_reg;
    rd_next          = 1'b0;
    wr_next          = 1'b0;
    wdata_next       = wdata_reg;
    operand_location = ea_reg;
    go_ea            = 1'b0;
    fl               = 1'b0;
    unique case (state_reg)
      ST_FETCH:
      begin
        addr_next  = pc_reg;
        rd_next    = 1'b1;
        state_next = ST_DEC;
      end
      // five classes split on the high nibble
      ST_DEC:
      begin
        op_next = mem_rdata;
        if (hi == CLS_RMW_A || hi == CLS_RMW_X)
        begin
          fl = 1'b1;
          if (rmw_wr(lo) && hi == CLS_RMW_A)
            acc_next = alu_bus.res;
          else if (rmw_wr(lo))
            idx_next = alu_bus.res;
          pc_next    = pc_reg + 16'h0001;
          state_next = ST_FETCH;
        end
        else if (hi == CLS_CTL8 || hi == CLS_CTL9)
        begin
          pc_next    = pc_reg + 16'h0001;
          state_next = ST_FETCH;
          unique case (mem_rdata)
            OPC_TAX: idx_next = acc_reg;
            OPC_TXA: acc_next = idx_reg;
            OPC_SEC: ccr_next[CC_C] = 1'b1;
            OPC_CLC: ccr_next[CC_C] = 1'b0;
            OPC_SEI: ccr_next[CC_I] = 1'b1;
            OPC_CLI: ccr_next[CC_I] = 1'b0;
            OPC_RSP: sp_next = STACK_TOP;
            OPC_RTS:
            begin
              addr_next  = sp_reg + 16'h0001;
              rd_next    = 1'b1;
              sp_next    = sp_reg + 16'h0001;
              state_next = ST_POPH;
            end
            default: ;
          endcase
        end
        else if (hi == CLS_IX || hi == CLS_RMW_IX)
        begin
          pc_next          = pc_reg + 16'h0001;
          operand_location = {8'h00, idx_reg};
          go_ea            = 1'b1;
        end
        else
        begin
          addr_next  = pc_reg + 16'h0001;
          rd_next    = 1'b1;
          state_next = ST_B1;
        end
      end
      // first byte after the opcode is on the bus
      ST_B1:
      begin
        b1_next = mem_rdata;
        if (hi == CLS_BRA)
        begin
          pc_next = pc_reg + 16'h0002;
          if (cond)
            pc_next = pc_reg + 16'h0002 + rel;
          state_next = ST_FETCH;
        end
        else if (op == OPC_BSR)
        begin
          ea_next    = pc_reg + 16'h0002 + rel;
          pc_next    = pc_reg + 16'h0002;
          state_next = ST_PSHL;
        end
        else if (hi == CLS_IMM)
        begin
          fl      = 1'b1;
          pc_next = pc_reg + 16'h0002;
          if (rm_dst(lo) == 2'h1)
            acc_next = alu_bus.res;
          else if (rm_dst(lo) == 2'h2)
            idx_next = alu_bus.res;
          state_next = ST_FETCH;
        end
        else if (hi == CLS_EXT || hi == CLS_IX2)
        begin
          addr_next  = pc_reg + 16'h0002;
          rd_next    = 1'b1;
          state_next = ST_B2;
        end
        else if (hi == CLS_IX1 || hi == CLS_RMW_IX1)
        begin
          pc_next          = pc_reg + 16'h0002;
          operand_location = {8'h00, idx_reg}
                           + {8'h00, mem_rdata};
          go_ea            = 1'b1;
        end
        else
        begin
          // direct page, bit set/clear and bit test all start here
          operand_location = {8'h00, mem_rdata};
          if (hi != CLS_BTB)
            pc_next = pc_reg + 16'h0002;
          go_ea = 1'b1;
        end
      end
      // second byte after the opcode is on the bus
      ST_B2:
      begin
        pc_next = pc_reg + 16'h0003;
        if (hi == CLS_EXT)
          operand_location = {b1_reg, mem_rdata};
        else
          operand_location = {b1_reg, mem_rdata}
                           + {8'h00, idx_reg};
        go_ea = 1'b1;
      end
      // operand byte is on the bus
      ST_OPR:
      begin
        state_next = ST_FETCH;
        if (regmem)
        begin
          fl = 1'b1;
          if (rm_dst(lo) == 2'h1)
            acc_next = alu_bus.res;
          else if (rm_dst(lo) == 2'h2)
            idx_next = alu_bus.res;
        end
        else if (hi == CLS_BSC)
        begin
          addr_next  = ea_reg;
          wdata_next = op[0] ? (mem_rdata & ~mask)
                             : (mem_rdata | mask);
          wr_next    = (ea_reg < BIT_ZONE_END);
        end
        else if (hi == CLS_BTB)
        begin
          ccr_next[CC_C] = mem_rdata[op[3:1]];
          addr_next      = pc_reg + 16'h0002;
          rd_next        = 1'b1;
          state_next     = ST_BRB;
        end
        else
        begin
          fl = 1'b1;
          if (rmw_wr(lo))
          begin
            addr_next  = ea_reg;
            wdata_next = alu_bus.res;
            wr_next    = 1'b1;
          end
        end
      end
      // bit test branch offset is on the bus
      ST_BRB:
      begin
        if (ccr_reg[CC_C] ^ op_reg[0])
          pc_next = pc_reg + 16'h0003 + rel;
        else
          pc_next = pc_reg + 16'h0003;
        state_next = ST_FETCH;
      end
      // return address low byte, then high byte
      ST_PSHL:
      begin
        addr_next  = sp_reg;
        wdata_next = pc_reg[7:0];
        wr_next    = 1'b1;
        sp_next    = sp_reg - 16'h0001;
        state_next = ST_PSHH;
      end
      ST_PSHH:
      begin
        addr_next  = sp_reg;
        wdata_next = pc_reg[15:8];
        wr_next    = 1'b1;
        sp_next    = sp_reg - 16'h0001;
        pc_next    = ea_reg;
        state_next = ST_FETCH;
      end
      // return address pops high first
      ST_POPH:
      begin
        pc_next[15:8] = mem_rdata;
        addr_next     = sp_reg + 16'h0001;
        rd_next       = 1'b1;
        sp_next       = sp_reg + 16'h0001;
        state_next    = ST_POPL;
      end
      ST_POPL:
      begin
        pc_next[7:0] = mem_rdata;
        state_next   = ST_FETCH;
      end
    endcase

    // use of the formed address, one of seven modes
    if (go_ea)
    begin
      ea_next = operand_location;
      if (regmem && lo == LO_JMP)
      begin
        pc_next    = operand_location;
        state_next = ST_FETCH;
      end
      else if (regmem && lo == LO_JSR)
        state_next = ST_PSHL;
      else if (regmem && (lo == LO_STA || lo == LO_STX))
      begin
        fl         = 1'b1;
        addr_next  = operand_location;
        wdata_next = alu_bus.res;
        wr_next    = 1'b1;
        state_next = ST_FETCH;
      end
      else
      begin
        addr_next  = operand_location;
        rd_next    = 1'b1;
        state_next = ST_OPR;
      end
    end

    // flag update from the alu result
    if (fl)
    begin
      ccr_next[CC_N] = alu_bus.res[7];
      ccr_next[CC_Z] = (alu_bus.res == 8'h00);
      if (alu_bus.c_upd)
        ccr_next[CC_C] = alu_bus.c;
      if (alu_bus.h_upd)
        ccr_next[CC_H] = alu_bus.h;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= ST_FETCH;
    else if (ce)
      state_reg <= state_next;
  end

  // programmer-visible registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_reg  <= RESET_PC;
      acc_reg <= 8'h00;
      idx_reg <= 8'h00;
      ccr_reg <= CCR_RESET;
      sp_reg  <= STACK_TOP;
    end
    else if (ce)
    begin
      pc_reg  <= pc_next;
      acc_reg <= acc_next;
      idx_reg <= idx_next;
      ccr_reg <= ccr_next;
      sp_reg  <= sp_next;
    end
  end

  // instruction holding registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_reg <= 8'h00;
      b1_reg <= 8'h00;
      ea_reg <= 16'h0000;
    end
    else if (ce)
    begin
      op_reg <= op_next;
      b1_reg <= b1_next;
      ea_reg <= ea_next;
    end
  end

  // memory bus outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_reg  <= 16'h0000;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      wdata_reg <= 8'h00;
    end
    else if (ce)
    begin
      addr_reg  <= addr_next;
      rd_reg    <= rd_next;
      wr_reg    <= wr_next;
      wdata_reg <= wdata_next;
    end
  end

  assign mem_addr  = addr_reg;
  assign mem_rd    = rd_reg;
  assign mem_wr    = wr_reg;
  assign mem_wdata = wdata_reg;
  assign acc       = acc_reg;
  assign idx       = idx_reg;
  assign pc        = pc_reg;
  assign ccr       = ccr_reg;

endmodule

// ===== eau_mem_model.sv
// partner: behavioural program and data memory on the unit's bus
`timescale 1ns/1ps
module eau_mem_model
(
  input  wire logic        clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg;

  // zero wait states; an idle bus shows the inverse of the last byte
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_reg;

  // plain always so the bench may preload the array
  always @(posedge clk)
  begin
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
    if (mem_rd)
      last_reg <= mem[mem_addr];
  end
endmodule

// ===== eau_chk.sv
// checker: bus and address relations of the address unit
`timescale 1ns/1ps
module eau_chk
  import eau_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic [7:0]  mem_rdata,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  idx,
  input wire logic [15:0] pc,
  input wire logic [4:0]  ccr
);
  logic       fetch;
  logic [7:0] op_q;
  logic [7:0] bmask;

  // opcode fetch is a read at the program counter
  assign fetch = ce && mem_rd && (mem_addr == pc);
  assign bmask = 8'h01 << op_q[3:1];

  // last opcode seen
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      op_q <= 8'h00;
    else if (fetch)
      op_q <= mem_rdata;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  rd_wr_excl_a: assert property (
    !(mem_rd && mem_wr)) else $error("read and write together");
  imm_mode_a: assert property (
    fetch && mem_rdata == 8'ha6 |=> mem_addr == $past(pc) + 16'h1
    ##1 pc == $past(pc, 2) + 16'h2 && acc == $past(mem_rdata)
    ##1 mem_rd && mem_addr == pc) else $error("immediate load wrong");
  ext_mode_a: assert property (
    fetch && (mem_rdata == 8'hc6 || mem_rdata == 8'hc7) |=> ##2
    (mem_rd || mem_wr)
    && mem_addr == {$past(mem_rdata, 2), $past(mem_rdata)})
    else $error("extended address wrong");
  ix1_carry_a: assert property (
    fetch && mem_rdata == 8'he6 |=> ##1 mem_rd
    && mem_addr == {8'h00, idx} + {8'h00, $past(mem_rdata)})
    else $error("indexed offset address wrong");
  tst_nowrite_a: assert property (
    fetch && mem_rdata == 8'h3d |=> !mem_wr [*3])
    else $error("test op wrote memory");
  rmw_wback_a: assert property (
    fetch && mem_rdata == 8'h3c |=> ##1 mem_rd ##1 mem_wr
    && $stable(mem_addr) && mem_wdata == $past(mem_rdata) + 8'h1)
    else $error("increment write-back wrong");
  bit_zone_a: assert property (
    fetch && mem_rdata[7:4] == 4'h1 |=> ##2
    mem_wr == (mem_addr < BIT_ZONE_END) && (!mem_wr
    || mem_wdata == (op_q[0] ? $past(mem_rdata) & ~bmask
    : $past(mem_rdata) | bmask))) else $error("bit set or clear wrong");
  brtest_carry_a: assert property (
    fetch && mem_rdata[7:4] == 4'h0 |=> ##2
    ccr[CC_C] == (|($past(mem_rdata) & bmask)) ##1
    pc == $past(pc, 4) + 16'h3 + ((ccr[CC_C] ^ op_q[0]) ?
    {{8{$past(mem_rdata[7])}}, $past(mem_rdata)} : 16'h0))
    else $error("bit test branch wrong");
  branch_rel_a: assert property (
    fetch && mem_rdata[7:1] == 7'h10 |=> ##2 mem_rd && mem_addr ==
    $past(pc, 3) + 16'h2 + (op_q[0] ? 16'h0 :
    {{8{$past(mem_rdata[7], 2)}}, $past(mem_rdata, 2)}))
    else $error("relative branch target wrong");
endmodule

bind eau_effective_address_unit eau_chk u_chk (.clk, .rst_b, .ce,
  .mem_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .acc, .idx, .pc,
  .ccr);

// ===== eau_tb.sv
// testbench: runs short programs through the address unit
`timescale 1ns/1ps
module testbench;
  import eau_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        ce;
  logic        irq_line;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_rdata;
  logic [7:0]  mem_wdata;
  logic [7:0]  acc;
  logic [7:0]  idx;
  logic [15:0] mem_addr;
  logic [15:0] pc;
  logic [4:0]  ccr;
  int          errors;
  int          n_compared;

  eau_effective_address_unit u_dut (.clk, .rst_b, .ce, .mem_rdata,
    .irq_line, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .acc, .idx, .pc,
    .ccr);
  eau_mem_model u_mem (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .mem_rdata);

  // clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // hold reset 16 cycles and load a program from address zero
  task automatic start(input logic [7:0] prog [$], input logic irq);
    @(posedge clk);
    rst_b <= 1'b0;
    irq_line <= irq;
    repeat (16) @(posedge clk);
    for (int i = 0; i < 65536; i++)
      u_mem.mem[i] = (i < prog.size()) ? prog[i] : 8'h00;
  endtask

  task automatic go(input int cycles);
    rst_b <= 1'b1;
    repeat (cycles) @(posedge clk);
    #1;
  endtask

  // compare pc at an opcode fetch, where it names the opcode
  task automatic check_pc(input logic [15:0] exp);
    int n;
    n = 0;
    while (!(mem_rd === 1'b1 && mem_addr === pc) && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(pc, exp);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic test_modes;
    start({8'ha6, 8'h55, 8'hae, 8'h90, 8'hf7, 8'he6, 8'h80, 8'hc7, 8'h01,
      8'h23, 8'hcc, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h40,
      8'h3d, 8'h41, 8'h20, 8'hfe}, 1'b1);
    u_mem.mem[16'h0110] = 8'ha7;
    u_mem.mem[16'h0040] = 8'h7f;
    u_mem.mem[16'h0041] = 8'h66;
    check(ccr, CCR_RESET);
    go(60);
    check(acc, 8'ha7);
    check(idx, 8'h90);
    check(u_mem.mem[16'h0090], 8'h55);
    check(u_mem.mem[16'h0123], 8'ha7);
    check(u_mem.mem[16'h0040], 8'h80);
    check(u_mem.mem[16'h0041], 8'h66);
    check_pc(16'h0014);
    $display("test_modes done");
  endtask

  task automatic test_bits;
    start({8'h4c, 8'h9d, 8'h16, 8'h40, 8'h17, 8'hc0, 8'h07, 8'h40, 8'h02,
      8'h0e, 8'hc0, 8'h01, 8'h4c, 8'h21, 8'h7f, 8'h2e, 8'h01, 8'h4c,
      8'h01, 8'h40, 8'h02, 8'h4c, 8'h4c, 8'h20, 8'hfe}, 1'b0);
    u_mem.mem[16'h00c0] = 8'hff;
    go(70);
    check(acc, 8'h01);
    check(u_mem.mem[16'h0040], 8'h08);
    check(u_mem.mem[16'h00c0], 8'hff);
    check(ccr[CC_C], 1'b0);
    check_pc(16'h0017);
    $display("test_bits done");
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    irq_line = 1'b1;
    test_modes;
    test_bits;
    summarize;
  end

  // watchdog well beyond the fewer than two hundred cycles the tests need
  initial
  begin
    #100000;
    errors++;
    summarize;
  end
endmodule
